// ### shared/sac_pkg.sv
// Constants and types for the converter control block.
// Assumes a core-side data-space bus with one-cycle read and write strobes.
package sac_pkg;
  localparam logic [7:0] SAC_ADDR_RESULT = 8'hd0;
  localparam logic [7:0] SAC_ADDR_CONTROL = 8'hd1;
  localparam logic [7:0] SAC_CONTROL_RESET = 8'h40;
  localparam int SAC_BIT_IRQ_EN = 7;
  localparam int SAC_BIT_DONE = 6;
  localparam int SAC_BIT_START = 5;
  localparam int SAC_BIT_POWER = 4;
  localparam int SAC_BIT_CLKSEL = 3;
  localparam int SAC_BIT_OSCILLATOR_OFF = 2;
  localparam int SAC_DIV_SLOW = 12;
  localparam int SAC_DIV_FAST = 6;
  localparam int SAC_CLK_PER_STEP = 8;
  localparam logic [3:0] SAC_IRQ_VECTOR = 4'h4;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sac_bus_req_t;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_SYNC = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;
endpackage

// ### rtl/sac_clkdiv.sv
// Conversion clock enable divider.
// Assumes one core clock; restart realigns the count.
`timescale 1ns/10ps
module sac_clkdiv #(
  parameter int CW = 4
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic restart_in,
  input wire logic run_in,
  input wire logic [CW-1:0] div_in,
  output logic tick_out
);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_reg <= '0;
      tick_out <= 1'b0;
    end
    else if (restart_in || !run_in)
    begin
      cnt_reg <= '0;
      tick_out <= 1'b0;
    end
    else if (cnt_reg == div_in - CW'(1))
    begin
      cnt_reg <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + CW'(1);
      tick_out <= 1'b0;
    end
  end
endmodule

// ### rtl/sac_top.sv
// Successive-approximation converter control with control and result registers.
// Assumes the analog comparator output is asynchronous; bus strobes are core-clock.
`timescale 1ns/10ps
module sac_top
  import sac_pkg::*;
#(
  parameter int STEP_CLKS = sac_pkg::SAC_CLK_PER_STEP
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire sac_pkg::sac_bus_req_t bus_in,
  input wire logic comp_in,
  input wire logic wait_entered_in,
  input wire logic sync_option_in,
  output logic [7:0] rdata_out,
  output logic [7:0] trial_out,
  output logic analog_power_out,
  output logic sample_out,
  output logic osc_off_out,
  output logic irq_out,
  output logic [3:0] irq_vector_out
);
  import sac_pkg::*;

  logic irq_en_reg;
  logic done_reg;
  logic power_reg;
  logic clksel_reg;
  logic osc_off_reg;
  logic [7:0] result_reg;
  logic [7:0] sar_reg;
  logic [2:0] bit_reg;
  logic [7:0] step_reg;
  sac_state_t state_reg;
  logic comp_m_reg;
  logic comp_s_reg;
  logic wait_m_reg;
  logic wait_s_reg;
  logic tick;
  logic start_wr;
  logic ctl_wr;
  logic step_end;

  function automatic logic [3:0] div_of(input logic fast);
    div_of = fast ? 4'(SAC_DIV_FAST) : 4'(SAC_DIV_SLOW);
  endfunction

  assign ctl_wr = bus_in.wr && (bus_in.addr == SAC_ADDR_CONTROL);
  assign start_wr = ctl_wr && bus_in.wdata[SAC_BIT_START];
  assign step_end = tick && (step_reg == 8'(STEP_CLKS - 1));

  // Clock enable: divide by 12 or 6
  sac_clkdiv #(
    .CW(4)
  ) u_div (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .restart_in(start_wr),
    .run_in(state_reg == SAC_CONV),
    .div_in(div_of(clksel_reg)),
    .tick_out(tick)
  );

  // Input synchronisers
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      comp_m_reg <= 1'b0;
      comp_s_reg <= 1'b0;
      wait_m_reg <= 1'b0;
      wait_s_reg <= 1'b0;
    end
    else
    begin
      comp_m_reg <= comp_in;
      comp_s_reg <= comp_m_reg;
      wait_m_reg <= wait_entered_in;
      wait_s_reg <= wait_m_reg;
    end
  end

  // Control register fields
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_en_reg <= SAC_CONTROL_RESET[SAC_BIT_IRQ_EN];
      power_reg <= SAC_CONTROL_RESET[SAC_BIT_POWER];
      clksel_reg <= SAC_CONTROL_RESET[SAC_BIT_CLKSEL];
      osc_off_reg <= SAC_CONTROL_RESET[SAC_BIT_OSCILLATOR_OFF];
    end
    else if (ctl_wr)
    begin
      irq_en_reg <= bus_in.wdata[SAC_BIT_IRQ_EN];
      power_reg <= bus_in.wdata[SAC_BIT_POWER];
      clksel_reg <= bus_in.wdata[SAC_BIT_CLKSEL];
      osc_off_reg <= bus_in.wdata[SAC_BIT_OSCILLATOR_OFF];
    end
  end

  // Sequencer
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= SAC_IDLE;
      sar_reg <= 8'h00;
      bit_reg <= 3'h7;
      step_reg <= 8'h00;
    end
    else if (start_wr)
    begin
      // Restart aborts any conversion in progress
      if (!bus_in.wdata[SAC_BIT_POWER])
      begin
        state_reg <= SAC_IDLE;
      end
      else
      begin
        state_reg <= sync_option_in ? SAC_SYNC : SAC_CONV;
      end
      sar_reg <= 8'h80;
      bit_reg <= 3'h7;
      step_reg <= 8'h00;
    end
    else if (!power_reg)
    begin
      state_reg <= SAC_IDLE;
    end
    else
    begin
      case (state_reg)
        SAC_IDLE:
        begin
          state_reg <= SAC_IDLE;
        end
        SAC_SYNC:
        begin
          if (wait_s_reg)
          begin
            state_reg <= SAC_CONV;
          end
        end
        SAC_CONV:
        begin
          if (tick)
          begin
            step_reg <= step_end ? 8'h00 : step_reg + 8'h01;
          end
          if (step_end)
          begin
            // Keep or drop trial bit, then try next
            if (!comp_s_reg)
            begin
              sar_reg[bit_reg] <= 1'b0;
            end
            if (bit_reg == 3'h0)
            begin
              state_reg <= SAC_IDLE;
            end
            else
            begin
              sar_reg[bit_reg - 3'h1] <= 1'b1;
              bit_reg <= bit_reg - 3'h1;
            end
          end
        end
        default:
        begin
          state_reg <= SAC_IDLE;
        end
      endcase
    end
  end

  // Result and completion flag
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      done_reg <= SAC_CONTROL_RESET[SAC_BIT_DONE];
      result_reg <= 8'h00;
    end
    else if (start_wr)
    begin
      done_reg <= 1'b0;
    end
    else if (state_reg == SAC_CONV && step_end && bit_reg == 3'h0 && power_reg)
    begin
      done_reg <= 1'b1;
      result_reg <= comp_s_reg ? sar_reg : (sar_reg & 8'hfe);
    end
  end

  // Outputs and read data
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rdata_out <= 8'h00;
      trial_out <= 8'h00;
      analog_power_out <= 1'b0;
      sample_out <= 1'b0;
      osc_off_out <= 1'b0;
      irq_out <= 1'b0;
      irq_vector_out <= SAC_IRQ_VECTOR;
    end
    else
    begin
      if (bus_in.rd && bus_in.addr == SAC_ADDR_CONTROL)
      begin
        rdata_out <= {irq_en_reg, done_reg, 1'b0, power_reg, clksel_reg,
          osc_off_reg, 2'b00};
      end
      else if (bus_in.rd && bus_in.addr == SAC_ADDR_RESULT)
      begin
        rdata_out <= result_reg;
      end
      else
      begin
        rdata_out <= 8'h00;
      end
      trial_out <= sar_reg;
      analog_power_out <= power_reg;
      sample_out <= (state_reg == SAC_CONV);
      osc_off_out <= osc_off_reg;
      irq_out <= done_reg && irq_en_reg;
      irq_vector_out <= SAC_IRQ_VECTOR;
    end
  end
endmodule

// ### tb/sac_checker.sv
// Port assertions for the converter control block.
// Assumes binding onto sac_top.
`timescale 1ns/10ps
module sac_checker
  import sac_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire sac_pkg::sac_bus_req_t bus_in,
  input wire logic sync_option_in,
  input wire logic [7:0] rdata_out,
  input wire logic analog_power_out,
  input wire logic sample_out,
  input wire logic osc_off_out,
  input wire logic irq_out,
  input wire logic [3:0] irq_vector_out
);
  import sac_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic wc;
  logic rc;
  logic st;
  assign wc = bus_in.wr && bus_in.addr == SAC_ADDR_CONTROL;
  assign rc = bus_in.rd && bus_in.addr == SAC_ADDR_CONTROL;
  assign st = wc && bus_in.wdata[SAC_BIT_START];
  a_vector_fixed: assert property (irq_vector_out == SAC_IRQ_VECTOR)
    else $error("bad vector");
  a_start_reads_zero: assert property (rc |=> !rdata_out[SAC_BIT_START])
    else $error("start bit read back");
  a_irq_tracks_flag: assert property (rc ##1 1'b1 |-> irq_out == (rdata_out[7] && rdata_out[6]))
    else $error("irq not flag and enable");
  a_start_clears: assert property (st |-> ##2 !irq_out)
    else $error("start left irq");
  a_start_runs: assert property (st && bus_in.wdata[SAC_BIT_POWER] && !sync_option_in |-> ##2 sample_out)
    else $error("start did not run");
  a_power_follows: assert property (wc |-> ##2 analog_power_out ==
    $past(bus_in.wdata[SAC_BIT_POWER], 2))
    else $error("power bit lost");
  a_osc_follows: assert property (wc |-> ##2 osc_off_out ==
    $past(bus_in.wdata[SAC_BIT_OSCILLATOR_OFF], 2))
    else $error("osc bit lost");
  a_no_rerun: assert property (!sample_out && !bus_in.wr && !$past(bus_in.wr) && !sync_option_in |=> !sample_out)
    else $error("conversion without start");
  a_power_gate: assert property (!analog_power_out [*3] |-> !sample_out)
    else $error("runs unpowered");
endmodule
bind sac_top sac_checker i_sac_checker (.core_clk_in, .sys_rst_in, .bus_in, .sync_option_in,
  .rdata_out, .analog_power_out, .sample_out, .osc_off_out, .irq_out, .irq_vector_out);

// ### tb/sac_comp_model.sv
// Ideal comparator for the analog side.
// Assumes the bench sets the input level.
`timescale 1ns/10ps
module sac_comp_model (
  input wire logic [7:0] trial_in,
  input wire logic [7:0] level_in,
  output logic comp_out
);
  assign comp_out = level_in >= trial_in;
endmodule

// ### tb/sac_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes one tick per bit step and the comparator model.
`timescale 1ns/10ps
module sac_top_tb;
  import sac_pkg::*;
  logic core_clk_in = 0;
  logic sys_rst_in = 1;
  sac_bus_req_t bus_in = '0;
  logic wait_entered_in = 0;
  logic sync_option_in = 0;
  logic [7:0] level = 8'h00;
  logic [7:0] rdata_out, trial_out, d, c;
  logic comp_in, sample_out, irq_out;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  sac_top #(.STEP_CLKS(1)) i_sac_top (.core_clk_in, .sys_rst_in, .bus_in, .comp_in,
    .wait_entered_in, .sync_option_in, .rdata_out, .trial_out, .analog_power_out(),
    .sample_out, .osc_off_out(), .irq_out, .irq_vector_out());
  sac_comp_model i_sac_comp_model (.trial_in(trial_out), .level_in(level), .comp_out(comp_in));
  initial
  begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    bus_in <= '{rd: r, wr: !r, addr: a, wdata: v};
    @(posedge core_clk_in);
    bus_in <= '0;
    #1;
    d = rdata_out;
  endtask
  function automatic logic [7:0] sar_exp(input logic [7:0] lv);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--)
      if (lv >= (r | (8'h01 << b)))
        r = r | (8'h01 << b);
    return r;
  endfunction
  task automatic conv(input logic [7:0] lv, input logic [7:0] cv, input int dv);
    int n;
    @(posedge core_clk_in);
    level <= lv;
    xfer(0, SAC_ADDR_CONTROL, cv | 8'h20);
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    while ((sample_out !== 1'b0 || n < 3) && n < 2000);
    chk(8'(n > 8 * dv - 3 && n < 8 * dv + 7), 8'h01);
    xfer(0, SAC_ADDR_RESULT, ~lv);
    xfer(1, SAC_ADDR_RESULT, 8'h00);
    chk(d, sar_exp(lv));
    xfer(1, SAC_ADDR_CONTROL, 8'h00);
    chk(d, cv | 8'h40);
    chk({7'h0, irq_out}, {7'h0, cv[7]});
    xfer(0, SAC_ADDR_CONTROL, cv);
    xfer(1, SAC_ADDR_CONTROL, 8'h00);
    chk(d, cv | 8'h40);
  endtask
  initial
  begin
    void'($urandom(32'h8319));
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    xfer(1, SAC_ADDR_CONTROL, 8'h00);
    chk(d, SAC_CONTROL_RESET);
    for (int i = 0; i < 12; i++)
    begin
      c = {i[1], 3'b001, i[0], 1'($urandom), 2'b00};
      xfer(0, SAC_ADDR_CONTROL, c);
      conv(i < 2 ? {8{i[0]}} : 8'($urandom), c, i[0] ? SAC_DIV_FAST : SAC_DIV_SLOW);
    end
    xfer(0, SAC_ADDR_CONTROL, 8'h30);
    repeat (30) @(posedge core_clk_in);
    conv(8'h5a, 8'h10, SAC_DIV_SLOW);
    xfer(0, SAC_ADDR_CONTROL, 8'h20);
    repeat (120) @(posedge core_clk_in);
    xfer(1, SAC_ADDR_CONTROL, 8'h00);
    chk(d, 8'h00);
    chk({7'h0, sample_out}, 8'h00);
    xfer(0, SAC_ADDR_CONTROL, 8'h90);
    sync_option_in <= 1'b1;
    level <= 8'hc3;
    xfer(0, SAC_ADDR_CONTROL, 8'hb0);
    repeat (150) @(posedge core_clk_in);
    xfer(1, SAC_ADDR_CONTROL, 8'h00);
    chk(d, 8'h90);
    wait_entered_in <= 1'b1;
    for (int k = 0; k < 300 && irq_out !== 1'b1; k++)
      @(posedge core_clk_in);
    xfer(1, SAC_ADDR_RESULT, 8'h00);
    chk(d, sar_exp(8'hc3));
    wait_entered_in <= 1'b0;
    level <= 8'h3c;
    xfer(0, SAC_ADDR_CONTROL, 8'hb8);
    wait_entered_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    for (int k = 0; k < 300 && irq_out !== 1'b1; k++)
      @(posedge core_clk_in);
    xfer(1, SAC_ADDR_RESULT, 8'h00);
    chk(d, sar_exp(8'h3c));
    sync_option_in <= 1'b0;
    wait_entered_in <= 1'b0;
    xfer(0, SAC_ADDR_CONTROL, 8'hb8);
    repeat (20) @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    xfer(1, SAC_ADDR_CONTROL, 8'h00);
    chk(d, SAC_CONTROL_RESET);
    chk({7'h0, sample_out}, 8'h00);
    end_sim();
  end
endmodule
